/* fpla_autopd.v */
`include "fpla_map.vh"

module fpla_autopd #(
  parameter PD_CYCLES = `FPLA_PD_TIME_MS * `FPLA_CLK_KHZ,
  parameter CW = 20
) (
  // clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // conditions
  input wire auto_en_i,
  input wire motors_off_i,
  input wire idle_i,
  input wire hut_expired_i,
  input wire dsr_pd_i,
  // events
  input wire restart_i,
  input wire wake_i,
  // state
  output reg asleep_o
);

  // last count value, cut to the counter width on purpose
  localparam [31:0] LAST_W = PD_CYCLES - 1;
  localparam [CW-1:0] LAST = LAST_W[CW-1:0];

  reg [CW-1:0] cnt_q;
  reg done_q;
  reg dsr_pd_q;

  // powerdown timer, cleared while disabled or under rate-select powerdown, and on restart or wake
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cnt_q <= {CW{1'b0}};
      done_q <= 1'b0;
      dsr_pd_q <= 1'b0;
    end
    else
    begin
      dsr_pd_q <= dsr_pd_i;
      if (!auto_en_i || restart_i || wake_i || dsr_pd_i || dsr_pd_q)
      begin
        cnt_q <= {CW{1'b0}};
        done_q <= 1'b0;
      end
      else if (!done_q)
      begin
        if (cnt_q == LAST)
          done_q <= 1'b1;
        else
          cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // sleep entry once every condition holds, wake on any waking access
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      asleep_o <= 1'b0;
    else if (!auto_en_i || wake_i || dsr_pd_i)
      asleep_o <= 1'b0;
    else if (done_q && motors_off_i && idle_i && hut_expired_i)
      asleep_o <= 1'b1;
  end

endmodule

/* fpla_core.v */
`include "fpla_map.vh"

module fpla_core #(
  parameter PD_CYCLES = `FPLA_PD_TIME_MS * `FPLA_CLK_KHZ,
  parameter PD_CW = 20
) (
  // clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // host register port, strobes one cycle wide
  input wire [2:0] addr_i,
  input wire rd_i,
  input wire wr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  // data register exchange with command engine
  input wire [7:0] data_rd_byte_i,
  output reg data_wr_o,
  output reg [7:0] data_wr_byte_o,
  output reg data_rd_o,
  // status sources for read registers and auto powerdown
  input wire [7:0] status_a_i,
  input wire [7:0] status_b_i,
  input wire [7:0] main_state_i,
  input wire [7:0] digital_in_i,
  input wire int_pending_i,
  input wire hut_expired_i,
  // decoded commands
  input wire perp_cmd_i,
  input wire [7:0] perp_byte_i,
  input wire cfg_cmd_i,
  input wire cfg_queue_disable_i,
  input wire [3:0] cfg_queue_threshold_i,
  input wire [7:0] cfg_precomp_start_track_i,
  input wire lock_cmd_i,
  input wire lock_bit_i,
  // configuration register bits
  input wire cfg_reg_zero_pd_i,
  input wire cfg_reg_seven_auto_i,
  // format timing from data path
  input wire [1:0] drive_sel_i,
  input wire rd_spacing_start_i,
  input wire wr_spacing_start_i,
  input wire byte_tick_i,
  input wire field_end_i,
  // timing outputs
  output reg pll_osc_enable_o,
  output reg write_gate_o,
  output reg [5:0] spacing_len_o,
  output reg precomp_zero_o,
  // queue settings
  output reg queue_disable_bit_o,
  output reg [3:0] queue_threshold_o,
  output reg [7:0] precomp_start_track_o,
  // results
  output reg lock_result_valid_o,
  output reg [7:0] lock_result_o,
  output reg [7:0] dump_byte8_o,
  // control outputs
  output reg [7:0] drive_output_control_o,
  output reg [1:0] data_rate_o,
  output reg sw_reset_o,
  output reg powered_down_o
);

  // ------------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------------

  // effective mode of one drive from global bits, flag and rate
  function [1:0] eff_mode;
    input wg;
    input gp;
    input flag;
    input [1:0] rate;
    begin
      if (gp && wg)
        eff_mode = `FPLA_MODE_P1M;
      else if (gp)
        eff_mode = `FPLA_MODE_P500;
      else if (!wg && flag && rate == `FPLA_RATE_1M)
        eff_mode = `FPLA_MODE_P1M;
      else if (!wg && flag)
        eff_mode = `FPLA_MODE_P500;
      else
        eff_mode = `FPLA_MODE_CONV;
    end
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------

  reg [7:0] doc_q;
  reg [1:0] rate_q;
  reg dsr_pd_q;
  reg early_write_enable_bit_q;
  reg gap_q;
  reg [3:0] flags_q;
  reg lock_q;
  reg qdis_q;
  reg [3:0] qthr_q;
  reg [7:0] precomp_start_track_q;
  reg [5:0] cnt_q;
  reg rd_act_q;
  reg wr_act_q;
  wire asleep;

  wire wr_doc = wr_i && (addr_i == `FPLA_OFS_DRV_OUT);
  wire wr_rsw = wr_i && (addr_i == `FPLA_OFS_RATE_SEL);
  wire wr_rct = wr_i && (addr_i == `FPLA_OFS_RATE_CTL);
  wire rd_msr = rd_i && (addr_i == `FPLA_OFS_MAIN_ST);
  wire data_acc = (rd_i || wr_i) && (addr_i == `FPLA_OFS_DATA);

  // software reset from either register
  wire sw_rst = (wr_doc && !wdata_i[`FPLA_DOC_RESET_N]) ||
                (wr_rsw && wdata_i[`FPLA_RSW_SW_RESET]);

  // newly enabled motors
  wire motor_up = wr_doc &&
    |(wdata_i[`FPLA_DOC_MOTOR_HI:`FPLA_DOC_MOTOR_LO] &
      ~doc_q[`FPLA_DOC_MOTOR_HI:`FPLA_DOC_MOTOR_LO]);

  wire wake = sw_rst || motor_up || rd_msr || data_acc;

  wire [1:0] mode = eff_mode(early_write_enable_bit_q, gap_q, flags_q[drive_sel_i], rate_q);

  reg [5:0] spc_len;
  reg [5:0] wg_at;
  reg [5:0] osc_at;
  always @*
  begin
    spc_len = `FPLA_SPC_CONV;
    wg_at = `FPLA_SPC_CONV;
    osc_at = `FPLA_OSC_CONV;
    case (mode)
      `FPLA_MODE_P500:
      begin
        wg_at = `FPLA_SPC_CONV - `FPLA_WR_P500;
      end
      `FPLA_MODE_P1M:
      begin
        spc_len = `FPLA_SPC_P1M;
        wg_at = `FPLA_SPC_P1M - `FPLA_WR_P1M;
        osc_at = `FPLA_OSC_P1M;
      end
      default:
      begin
        spc_len = `FPLA_SPC_CONV;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // host registers
  // ------------------------------------------------------------------

  // drive output, rate and rate-select powerdown; writes taken even when asleep
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      doc_q <= `FPLA_DOC_RESET;
      rate_q <= `FPLA_RATE_RESET;
      dsr_pd_q <= 1'b0;
    end
    else
    begin
      if (wr_doc)
        doc_q <= wdata_i;
      if (wr_rsw)
        rate_q <= wdata_i[1:0];
      else if (wr_rct)
        rate_q <= wdata_i[1:0];
      // rate-select powerdown until reset, set wins
      if (wr_rsw && wdata_i[`FPLA_RSW_PWRDN])
        dsr_pd_q <= 1'b1;
      else if (sw_rst)
        dsr_pd_q <= 1'b0;
    end
  end

  // read mux; true status returned even while asleep
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rdata_o <= 8'h00;
    else if (rd_i)
    begin
      case (addr_i)
        `FPLA_OFS_STAT_A: rdata_o <= status_a_i;
        `FPLA_OFS_STAT_B: rdata_o <= status_b_i;
        `FPLA_OFS_DRV_OUT: rdata_o <= doc_q;
        `FPLA_OFS_MAIN_ST: rdata_o <= main_state_i;
        `FPLA_OFS_DATA: rdata_o <= data_rd_byte_i;
        `FPLA_OFS_DIG_IN: rdata_o <= digital_in_i;
        default: rdata_o <= 8'h00;
      endcase
    end
  end

  // data register strobes toward command engine
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      data_wr_o <= 1'b0;
      data_wr_byte_o <= 8'h00;
      data_rd_o <= 1'b0;
    end
    else
    begin
      data_wr_o <= wr_i && (addr_i == `FPLA_OFS_DATA);
      data_rd_o <= rd_i && (addr_i == `FPLA_OFS_DATA);
      if (wr_i && (addr_i == `FPLA_OFS_DATA))
        data_wr_byte_o <= wdata_i;
    end
  end

  // ------------------------------------------------------------------
  // perpendicular and lock state
  // ------------------------------------------------------------------

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      early_write_enable_bit_q <= 1'b0;
      gap_q <= 1'b0;
      flags_q <= 4'h0;
    end
    else if (sw_rst)
    begin
      early_write_enable_bit_q <= 1'b0;
      gap_q <= 1'b0;
    end
    else if (perp_cmd_i)
    begin
      early_write_enable_bit_q <= perp_byte_i[`FPLA_PC_EARLY_WRITE_ENABLE_BIT];
      gap_q <= perp_byte_i[`FPLA_PC_GAP];
      if (perp_byte_i[`FPLA_PC_OW])
        flags_q <= perp_byte_i[`FPLA_PC_FLAG_HI:`FPLA_PC_FLAG_LO];
    end
  end

  // retain flag and queue settings
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      lock_q <= 1'b0;
      qdis_q <= `FPLA_QDIS_DEF;
      qthr_q <= `FPLA_QTHR_DEF;
      precomp_start_track_q <= `FPLA_PRECOMP_START_TRACK_DEF;
    end
    else
    begin
      if (lock_cmd_i)
        lock_q <= lock_bit_i;
      if (cfg_cmd_i)
      begin
        qdis_q <= cfg_queue_disable_i;
        qthr_q <= cfg_queue_threshold_i;
        precomp_start_track_q <= cfg_precomp_start_track_i;
      end
      else if (sw_rst && !lock_q)
      begin
        qdis_q <= `FPLA_QDIS_DEF;
        qthr_q <= `FPLA_QTHR_DEF;
        precomp_start_track_q <= `FPLA_PRECOMP_START_TRACK_DEF;
      end
    end
  end

  // lock answer and dump byte
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      lock_result_valid_o <= 1'b0;
      lock_result_o <= 8'h00;
      dump_byte8_o <= 8'h00;
    end
    else
    begin
      lock_result_valid_o <= lock_cmd_i;
      if (lock_cmd_i)
        lock_result_o <= {7'h00, lock_bit_i} << `FPLA_LOCK_RES_BIT;
      dump_byte8_o <= {lock_q, 1'b0, flags_q, gap_q, early_write_enable_bit_q};
    end
  end

  // ------------------------------------------------------------------
  // spacing field sequencer
  // ------------------------------------------------------------------

  // byte count from start of spacing field
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cnt_q <= 6'h00;
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
    end
    else if (field_end_i)
    begin
      cnt_q <= 6'h00;
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
    end
    else if (rd_spacing_start_i || wr_spacing_start_i)
    begin
      cnt_q <= 6'h00;
      rd_act_q <= rd_spacing_start_i;
      wr_act_q <= wr_spacing_start_i;
    end
    else if (byte_tick_i && (rd_act_q || wr_act_q) && cnt_q != 6'h3F)
      cnt_q <= cnt_q + 6'h01;
  end

  // oscillator enable and write gate
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pll_osc_enable_o <= 1'b0;
      write_gate_o <= 1'b0;
    end
    else if (field_end_i || rd_spacing_start_i || wr_spacing_start_i)
    begin
      pll_osc_enable_o <= 1'b0;
      write_gate_o <= 1'b0;
    end
    else
    begin
      if (rd_act_q && cnt_q >= osc_at)
        pll_osc_enable_o <= 1'b1;
      // write gate at sync start or earlier
      if (wr_act_q && cnt_q >= wg_at)
        write_gate_o <= 1'b1;
    end
  end

  // spacing length and precompensation selection
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      spacing_len_o <= `FPLA_SPC_CONV;
      precomp_zero_o <= 1'b0;
    end
    else
    begin
      // length from both global bits, or from rate for flagged drive
      spacing_len_o <= spc_len;
      // zero precomp only for perpendicular drive
      precomp_zero_o <= (mode != `FPLA_MODE_CONV);
    end
  end

  // ------------------------------------------------------------------
  // power management
  // ------------------------------------------------------------------

  fpla_autopd #(
    .PD_CYCLES(PD_CYCLES),
    .CW(PD_CW)
  ) u_autopd (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .auto_en_i(cfg_reg_seven_auto_i),
    .motors_off_i(doc_q[`FPLA_DOC_MOTOR_HI:`FPLA_DOC_MOTOR_LO] == 4'h0),
    .idle_i(main_state_i == `FPLA_IDLE_MSR && !int_pending_i),
    .hut_expired_i(hut_expired_i),
    .dsr_pd_i(dsr_pd_q),
    .restart_i(rd_msr || data_acc),
    .wake_i(wake),
    .asleep_o(asleep)
  );

  // outputs mirrored from state
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      queue_disable_bit_o <= `FPLA_QDIS_DEF;
      queue_threshold_o <= `FPLA_QTHR_DEF;
      precomp_start_track_o <= `FPLA_PRECOMP_START_TRACK_DEF;
      drive_output_control_o <= `FPLA_DOC_RESET;
      data_rate_o <= `FPLA_RATE_RESET;
      sw_reset_o <= 1'b0;
      powered_down_o <= 1'b0;
    end
    else
    begin
      queue_disable_bit_o <= qdis_q;
      queue_threshold_o <= qthr_q;
      precomp_start_track_o <= precomp_start_track_q;
      drive_output_control_o <= doc_q;
      data_rate_o <= rate_q;
      sw_reset_o <= sw_rst;
      powered_down_o <= cfg_reg_zero_pd_i || dsr_pd_q || asleep;
    end
  end

endmodule

/* fpla_core_properties.sv */
module fpla_core_chk #(
  parameter PD_CYCLES = 20
) (
  // clock and reset
  input logic clk_i,
  input logic sys_rst_i,
  // command and timing inputs
  input logic lock_cmd_i,
  input logic lock_bit_i,
  input logic [1:0] drive_sel_i,
  input logic rd_spacing_start_i,
  input logic wr_spacing_start_i,
  input logic byte_tick_i,
  input logic hut_expired_i,
  input logic int_pending_i,
  input logic cfg_reg_zero_pd_i,
  // watched outputs
  input logic pll_osc_enable_o,
  input logic write_gate_o,
  input logic [5:0] spacing_len_o,
  input logic precomp_zero_o,
  input logic queue_disable_bit_o,
  input logic [3:0] queue_threshold_o,
  input logic [7:0] precomp_start_track_o,
  input logic lock_result_valid_o,
  input logic [7:0] lock_result_o,
  input logic [7:0] dump_byte8_o,
  input logic [7:0] drive_output_control_o,
  input logic sw_reset_o,
  input logic powered_down_o
);
  // ----------------------------------------
  // timing relations
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [5:0] bytes_q;
  // byte count since the last spacing field start
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      bytes_q <= 6'h00;
    else if (rd_spacing_start_i || wr_spacing_start_i)
      bytes_q <= 6'h00;
    else if (byte_tick_i)
      bytes_q <= bytes_q + 6'h01;
  end
  property p_lock_res;
    lock_cmd_i |=> lock_result_valid_o && lock_result_o[4] == $past(lock_bit_i);
  endproperty
  property p_osc_at;
    $rose(pll_osc_enable_o) |-> bytes_q == 6'h18 || bytes_q == 6'h2B;
  endproperty
  property p_wg_at;
    $rose(write_gate_o) |-> bytes_q == 6'h16 || bytes_q == 6'h03;
  endproperty
  property p_sp_1m;
    dump_byte8_o[1:0] == 2'h3 && $stable(dump_byte8_o) |-> spacing_len_o == 6'h29;
  endproperty
  property p_flag;
    $stable(dump_byte8_o) && $stable(drive_sel_i) |-> precomp_zero_o ==
      (dump_byte8_o[1] ||
      (dump_byte8_o[1:0] == 2'h0 && dump_byte8_o[2 + drive_sel_i]));
  endproperty
  property p_sw_glob;
    sw_reset_o |-> ##2 (dump_byte8_o[1:0] == 2'h0 &&
      dump_byte8_o[5:2] == $past(dump_byte8_o[5:2], 2));
  endproperty
  property p_keep;
    sw_reset_o && dump_byte8_o[7] |-> ##2 (queue_threshold_o ==
      $past(queue_threshold_o, 2) &&
      precomp_start_track_o == $past(precomp_start_track_o, 2));
  endproperty
  property p_dflt;
    sw_reset_o && !dump_byte8_o[7] |-> ##2 (queue_disable_bit_o &&
      queue_threshold_o == 4'h0 && precomp_start_track_o == 8'h00);
  endproperty
  property p_sleep;
    $rose(powered_down_o) && !cfg_reg_zero_pd_i |->
      drive_output_control_o[7:4] == 4'h0 && hut_expired_i && !int_pending_i;
  endproperty
  property p_direct;
    cfg_reg_zero_pd_i [*4] |-> powered_down_o;
  endproperty
  a_lock_res: assert property (p_lock_res) else $error("lock result");
  a_osc_at: assert property (p_osc_at) else $error("osc start");
  a_wg_at: assert property (p_wg_at) else $error("gate start");
  a_sp_1m: assert property (p_sp_1m) else $error("spacing len");
  a_flag: assert property (p_flag) else $error("drive flag");
  a_sw_glob: assert property (p_sw_glob) else $error("sw reset");
  a_keep: assert property (p_keep) else $error("settings lost");
  a_dflt: assert property (p_dflt) else $error("no defaults");
  a_sleep: assert property (p_sleep) else $error("bad sleep");
  a_direct: assert property (p_direct) else $error("no powerdown");
  c_wake: cover property (powered_down_o ##[1:40] !powered_down_o);
  c_lock: cover property (lock_result_valid_o && lock_result_o[4]);
  c_osc43: cover property ($rose(pll_osc_enable_o) && bytes_q == 6'h2B);
endmodule
bind fpla_core fpla_core_chk #(.PD_CYCLES(PD_CYCLES)) u_chk (.*);

/* fpla_far_model.sv */
module fpla_far_model (
  // clock and control
  input logic clk_i,
  input logic idle_i,
  // status and data sources
  output logic [7:0] status_a_o,
  output logic [7:0] status_b_o,
  output logic [7:0] main_state_o,
  output logic [7:0] digital_in_o,
  output logic [7:0] data_byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pat_q = 8'h5A;
  // pattern moves every cycle so stale values never match
  always @(posedge clk_i)
    pat_q <= pat_q + 8'h35;
  // status, digital-in and data sources derived from the pattern; main state from idle_i
  assign status_a_o = pat_q;
  assign status_b_o = ~pat_q;
  assign digital_in_o = {pat_q[3:0], pat_q[7:4]};
  assign data_byte_o = pat_q ^ 8'hC3;
  assign main_state_o = idle_i ? 8'h80 : 8'hD0;
endmodule

/* fpla_map.vh */
`ifndef FPLA_MAP_VH
`define FPLA_MAP_VH

// host register offsets
`define FPLA_OFS_STAT_A 3'h0
`define FPLA_OFS_STAT_B 3'h1
`define FPLA_OFS_DRV_OUT 3'h2
`define FPLA_OFS_RATE_SEL 3'h4
`define FPLA_OFS_MAIN_ST 3'h4
`define FPLA_OFS_DATA 3'h5
`define FPLA_OFS_DIG_IN 3'h7
`define FPLA_OFS_RATE_CTL 3'h7

// drive_output_control fields
`define FPLA_DOC_MOTOR_HI 7
`define FPLA_DOC_MOTOR_LO 4
`define FPLA_DOC_RESET_N 2
`define FPLA_DOC_RESET 8'h0C

// rate_select_write fields
`define FPLA_RSW_SW_RESET 7
`define FPLA_RSW_PWRDN 6
`define FPLA_RSW_RESET 8'h02

// perpendicular command byte fields
`define FPLA_PC_EARLY_WRITE_ENABLE_BIT 0
`define FPLA_PC_GAP 1
`define FPLA_PC_FLAG_LO 2
`define FPLA_PC_FLAG_HI 5
`define FPLA_PC_OW 7

// data rate codes and rate reset
`define FPLA_RATE_1M 2'h3
`define FPLA_RATE_RESET 2'h2

// queue settings defaults
`define FPLA_QDIS_DEF 1'h1
`define FPLA_QTHR_DEF 4'h0
`define FPLA_PRECOMP_START_TRACK_DEF 8'h00

// lock result byte position
`define FPLA_LOCK_RES_BIT 4

// spacing field byte counts
`define FPLA_SPC_CONV 6'h16
`define FPLA_SPC_P1M 6'h29
`define FPLA_WR_P500 6'h13
`define FPLA_WR_P1M 6'h26
`define FPLA_OSC_CONV 6'h18
`define FPLA_OSC_P1M 6'h2B

// effective recording modes
`define FPLA_MODE_CONV 2'h0
`define FPLA_MODE_P500 2'h1
`define FPLA_MODE_P1M 2'h2

// powerdown interval and clock
`define FPLA_PD_TIME_MS 10
`define FPLA_CLK_KHZ 100000
`define FPLA_IDLE_MSR 8'h80

`endif

/* tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PD = 20;
  logic clk_i, sys_rst_i, rd_i, wr_i, int_pending_i, hut_expired_i, idle;
  logic perp_cmd_i, cfg_cmd_i, cfg_queue_disable_i, lock_cmd_i, lock_bit_i;
  logic cfg_reg_zero_pd_i, cfg_reg_seven_auto_i, rd_spacing_start_i, rd_d;
  logic wr_spacing_start_i, byte_tick_i, field_end_i, data_wr_o, data_rd_o;
  logic pll_osc_enable_o, write_gate_o, precomp_zero_o, queue_disable_bit_o;
  logic lock_result_valid_o, sw_reset_o, powered_down_o;
  logic [1:0] drive_sel_i, data_rate_o;
  logic [2:0] addr_i;
  logic [3:0] cfg_queue_threshold_i, queue_threshold_o, fl;
  logic [5:0] spacing_len_o;
  logic [7:0] wdata_i, perp_byte_i, cfg_precomp_start_track_i, rdata_o;
  logic [7:0] data_rd_byte_i, status_a_i, status_b_i, main_state_i, doc_m;
  logic [7:0] digital_in_i, data_wr_byte_o, lock_result_o, dump_byte8_o;
  logic [7:0] drive_output_control_o, precomp_start_track_o, trk;
  logic [7:0] exp_q[$];
  int err_total, comparisons;
  fpla_core #(.PD_CYCLES(PD)) uut (.*);
  fpla_far_model u_far (.clk_i(clk_i), .idle_i(idle),
    .status_a_o(status_a_i), .status_b_o(status_b_i),
    .main_state_o(main_state_i), .digital_in_o(digital_in_i),
    .data_byte_o(data_rd_byte_i));
  // ----------------------------------------
  // clock, tasks and checking
  // ----------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic stop_test;
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [7:0] exp_rd(input logic [2:0] a);
    case (a)
      3'h0: return status_a_i;
      3'h1: return status_b_i;
      3'h2: return doc_m;
      3'h4: return main_state_i;
      3'h5: return data_rd_byte_i;
      3'h7: return digital_in_i;
      default: return 8'h00;
    endcase
  endfunction
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    logic sr;
    sr = w && ((a == 3'h2 && !d[2]) || (a == 3'h4 && d[7]));
    @(posedge clk_i);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    if (!w)
      exp_q.push_back(exp_rd(a));
    else if (a == 3'h2)
      doc_m = d;
    rd_i <= 1'b0;
    wr_i <= 1'b0;
    @(negedge clk_i);
    chk("data_wr", data_wr_o, w && a == 3'h5);
    chk("data_rd", data_rd_o, !w && a == 3'h5);
    chk("sw_reset", sw_reset_o, sr);
    if (w && a == 3'h5)
      chk("data_byte", data_wr_byte_o, d);
    repeat (3) @(posedge clk_i);
  endtask
  task automatic perp(input logic [7:0] b);
    @(posedge clk_i);
    perp_cmd_i <= 1'b1;
    perp_byte_i <= b;
    @(posedge clk_i);
    perp_cmd_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic lock(input logic b);
    @(posedge clk_i);
    lock_cmd_i <= 1'b1;
    lock_bit_i <= b;
    exp_q.push_back({3'h0, b, 4'h0});
    @(posedge clk_i);
    lock_cmd_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic wait_pd(input logic e, input int lim);
    for (int i = 0; i < lim && powered_down_o !== e; i++)
      @(posedge clk_i);
    chk("powered_down", powered_down_o, e);
  endtask
  // run one spacing field for read then write, count bytes to each edge
  task automatic gap_run(input logic [7:0] pb, input int osc, wg, sp);
    int n;
    perp(pb);
    chk("spacing_len", spacing_len_o, sp);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_i);
      rd_spacing_start_i <= (k == 0);
      wr_spacing_start_i <= (k == 1);
      @(posedge clk_i);
      rd_spacing_start_i <= 1'b0;
      wr_spacing_start_i <= 1'b0;
      n = 0;
      while (n < 50 && (k ? write_gate_o : pll_osc_enable_o) !== 1'b1)
      begin
        byte_tick_i <= 1'b1;
        @(posedge clk_i);
        byte_tick_i <= 1'b0;
        n++;
        repeat (2) @(posedge clk_i);
      end
      chk(k ? "gate_bytes" : "osc_bytes", n, k ? wg : osc);
      field_end_i <= 1'b1;
      @(posedge clk_i);
      field_end_i <= 1'b0;
    end
  endtask
  // register and lock results leave in the order they were asked for
  always @(posedge clk_i)
    rd_d <= rd_i;
  always @(negedge clk_i)
    if (rd_d === 1'b1 || lock_result_valid_o === 1'b1)
      chk("result", lock_result_valid_o === 1'b1 ? lock_result_o : rdata_o,
        exp_q.size() ? exp_q.pop_front() : 8'hXX);
  // watchdog against a hang
  initial
  begin
    #100us;
    err_total++;
    stop_test();
  end
  // main sequence
  initial
  begin
    {rd_i, wr_i, int_pending_i, perp_cmd_i, cfg_cmd_i, lock_cmd_i} = '0;
    {cfg_queue_disable_i, lock_bit_i, cfg_reg_zero_pd_i} = '0;
    {cfg_reg_seven_auto_i, rd_spacing_start_i, wr_spacing_start_i} = '0;
    {byte_tick_i, field_end_i, drive_sel_i, addr_i, wdata_i} = '0;
    {perp_byte_i, cfg_queue_threshold_i, cfg_precomp_start_track_i} = '0;
    {sys_rst_i, hut_expired_i, idle, doc_m} = {3'h7, 8'h0C};
    trk = $urandom(6);
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    chk("doc", drive_output_control_o, 8'h0C);
    chk("rate", data_rate_o, 8'h02);
    chk("qdis", queue_disable_bit_o, 8'h01);
    chk("dump", dump_byte8_o, 8'h00);
    for (int a = 0; a < 8; a++)
      bus(1'b0, a[2:0], 8'h00);
    lock(1'b1);
    chk("dump_lock", dump_byte8_o[7], 1'b1);
    trk = $urandom;
    fl = $urandom;
    @(posedge clk_i);
    {cfg_cmd_i, cfg_queue_threshold_i, cfg_precomp_start_track_i} <= {1'b1, fl, trk};
    @(posedge clk_i);
    cfg_cmd_i <= 1'b0;
    bus(1'b1, 3'h2, 8'h08);
    bus(1'b1, 3'h2, 8'h0C);
    chk("thr", queue_threshold_o, fl);
    chk("trk", precomp_start_track_o, trk);
    lock(1'b0);
    bus(1'b1, 3'h4, 8'h82);
    chk("thr", queue_threshold_o, 8'h00);
    chk("trk", precomp_start_track_o, 8'h00);
    fl = $urandom;
    perp({2'h2, fl, 2'h0});
    bus(1'b1, 3'h7, 8'h03);
    for (int d = 0; d < 4; d++)
    begin
      drive_sel_i <= d[1:0];
      repeat (4) @(posedge clk_i);
      chk("pzero", precomp_zero_o, fl[d]);
      chk("sp", spacing_len_o, fl[d] ? 8'h29 : 8'h16);
    end
    perp({2'h0, ~fl, 2'h0});
    chk("flags", dump_byte8_o[5:2], fl);
    perp(8'h03);
    bus(1'b1, 3'h2, 8'h08);
    bus(1'b1, 3'h2, 8'h0C);
    chk("dump", dump_byte8_o[5:0], {fl, 2'h0});
    sys_rst_i <= 1'b1;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("dump", dump_byte8_o, 8'h00);
    gap_run(8'h00, 24, 22, 22);
    gap_run(8'h02, 24, 3, 22);
    gap_run(8'h01, 24, 22, 22);
    gap_run(8'h03, 43, 3, 41);
    bus(1'b1, 3'h4, 8'h82);
    cfg_reg_seven_auto_i <= 1'b1;
    wait_pd(1'b1, 3 * PD);
    bus(1'b0, 3'h2, 8'h00);
    bus(1'b1, 3'h7, 8'h01);
    wait_pd(1'b1, 1);
    bus(1'b0, 3'h4, 8'h00);
    wait_pd(1'b0, 4);
    chk("rate", data_rate_o, 8'h01);
    wait_pd(1'b1, 3 * PD);
    bus(1'b1, 3'h5, 8'h3C);
    wait_pd(1'b0, 4);
    wait_pd(1'b1, 3 * PD);
    bus(1'b1, 3'h2, 8'h1C);
    wait_pd(1'b0, 4);
    repeat (3 * PD) @(posedge clk_i);
    wait_pd(1'b0, 1);
    // busy, interrupt, head loaded each block sleep; all clear allows it
    for (int c = 0; c < 4; c++)
    begin
      {idle, int_pending_i, hut_expired_i} <= {c != 0, c == 1, c != 2};
      if (c == 0)
        bus(1'b1, 3'h2, 8'h0C);
      repeat (3 * PD) @(posedge clk_i);
      wait_pd(c == 3, 1);
    end
    wait_pd(1'b1, 3 * PD);
    bus(1'b0, 3'h4, 8'h00);
    cfg_reg_seven_auto_i <= 1'b0;
    repeat (3 * PD) @(posedge clk_i);
    wait_pd(1'b0, 1);
    bus(1'b1, 3'h4, 8'h42);
    wait_pd(1'b1, 8);
    bus(1'b0, 3'h4, 8'h00);
    wait_pd(1'b1, 1);
    bus(1'b1, 3'h4, 8'h82);
    wait_pd(1'b0, 4);
    cfg_reg_zero_pd_i <= 1'b1;
    wait_pd(1'b1, 8);
    cfg_reg_zero_pd_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    stop_test();
  end
endmodule
